// File: hpa_pkg.sv
// Constants shared by the hot-plug auxiliary fault logic
package hpa_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned WAKE_DELAY_US   = 100;
  // Longest-style wait: whole cycles, rounded down, never below one
  localparam int unsigned WAKE_DELAY_CYC  =
    (WAKE_DELAY_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
    WAKE_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WAKE_CNT_W      = 16;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NSLOT           = 2;
  localparam int unsigned SYNC_W          = 24;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_MASK   = 4'hC;

  // Control register fields
  localparam int unsigned CTRL_PWR_REQ    = 0;
  localparam int unsigned CTRL_ATT        = 2;
  localparam int unsigned CTRL_PWR_IND    = 4;
  localparam int unsigned CTRL_W          = 6;
  localparam logic [5:0]  CTRL_RST        = 6'h00;

  // Status register fields
  localparam int unsigned ST_AUX_FLT      = 0;
  localparam int unsigned ST_ANY_FLT      = 2;
  localparam int unsigned ST_WAKE_CONN    = 4;
  localparam int unsigned ST_AUX_EN       = 6;
  localparam int unsigned ST_STRAP        = 8;
  localparam int unsigned ST_MPV          = 10;
  localparam int unsigned ST_TEST_RISE    = 11;
  localparam int unsigned ST_CAP          = 12;
  localparam int unsigned ST_W            = 16;

  // Interrupt status / mask fields
  localparam int unsigned IRQ_AUX_FLT     = 0;
  localparam int unsigned IRQ_WAKE_CONN   = 2;
  localparam int unsigned IRQ_MPV_RISE    = 4;
  localparam int unsigned IRQ_W           = 5;
  localparam logic [4:0]  IRQ_RST         = 5'h00;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // Chain pins idle high like their pull-ups
  localparam logic        CHAIN_IDLE      = 1'b1;
  localparam logic [1:0]  STRAP_RST       = 2'h3;

endpackage : hpa_pkg

// File: hpa_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module hpa_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Data
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // ----------------------------------------------------------------
  // Two flops per bit; the first stage feeds only the second
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_q[i] <= rst_val[i];
          q[i]      <= rst_val[i];
        end else begin
          meta_q[i] <= d[i];
          q[i]      <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule : hpa_sync

// File: hpa_slot.sv
// One slot's auxiliary supply, fault latch and wake-event gate
`timescale 1ns/100ps
module hpa_slot
  import hpa_pkg::*;
#(
  parameter int unsigned DELAY_CYC = WAKE_DELAY_CYC
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Synchronised slot conditions
  input  wire logic sw_closed,
  input  wire logic aux_in_uv,
  input  wire logic aux_oc,
  input  wire logic aux_good,
  // Slot state
  output logic      aux_en_q,
  output logic      wake_conn_q,
  output logic      aux_fault
);
  import hpa_pkg::*;

  localparam logic [WAKE_CNT_W-1:0] DELAY_LAST = WAKE_CNT_W'(DELAY_CYC - 1);

  logic                  short_q;
  logic [WAKE_CNT_W-1:0] cnt_q;
  logic                  short_set;
  logic                  short_clr;
  logic                  kill;
  logic                  timing;

  // ----------------------------------------------------------------
  // Fault terms
  // ----------------------------------------------------------------
  assign short_set = sw_closed & aux_en_q & aux_oc;
  assign short_clr = ~sw_closed | aux_in_uv;
  assign aux_fault = short_q | aux_in_uv | short_set;
  // Open switch or fault drops the gate in the same cycle as the supply
  assign kill      = ~sw_closed | aux_fault;
  assign timing    = aux_en_q & aux_good & ~wake_conn_q;

  // Short-circuit latch: a new short wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      short_q <= 1'b0;
    end else if (short_set) begin
      short_q <= 1'b1;
    end else if (short_clr) begin
      short_q <= 1'b0;
    end
  end

  // Supply follows the interlock and drops on fault
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_en_q <= 1'b0;
    end else begin
      aux_en_q <= ~kill;
    end
  end

  // Settle timer starts once the supply is above threshold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (kill || !timing) begin
      cnt_q <= '0;
    end else if (cnt_q != DELAY_LAST) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Wake gate closes only at timer end; opens at once on kill
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_conn_q <= 1'b0;
    end else if (kill) begin
      wake_conn_q <= 1'b0;
    end else if (timing && cnt_q == DELAY_LAST) begin
      wake_conn_q <= 1'b1;
    end
  end

endmodule : hpa_slot

// File: hpa_aux_fault_logic.sv
// Top of the two-slot hot-plug auxiliary and fault logic
//
// Overview of operation
// - Nine-signal link, two cascaded chain pairs
// - Status chain upstream, control chain forwarded downstream
// - Chain output pins double as mode straps
// - Status pin is strap bit 0, control bit 1
// - Input undervoltage or slot overcurrent flags fault
// - Aux supply follows interlock switch
// - Wake gate connects after supply settle delay
// - Open switch or fault drops wake immediately
// - Short latches fault; switch open clears
// - Faults readable while main power valid
// - Without main power, attention shows aux fault unless at override level
// - Test select shows combined fault on attention
// - With main power valid, test select shows power request on indicator
// - Intermediate switch level shows main fault
// - Override level enables slot, shows main fault
// - Three-level capability strap decodes to two bits
`timescale 1ns/100ps
module hpa_aux_fault_logic #(
  parameter int unsigned WAKE_DELAY = hpa_pkg::WAKE_DELAY_CYC
) (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write address
  input  wire logic [3:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Interrupt
  output logic                            irq,
  // Cascaded serial link
  input  wire logic                       link_clk,
  input  wire logic                       status_chain_in,
  input  wire logic                       status_chain_out_i,
  output logic                            status_chain_out_o,
  output logic                            status_chain_out_oe,
  input  wire logic                       control_chain_in,
  input  wire logic                       control_chain_out_i,
  output logic                            control_chain_out_o,
  output logic                            control_chain_out_oe,
  // System conditions
  input  wire logic                       main_power_valid,
  input  wire logic                       test_select,
  input  wire logic                       aux_in_uv,
  // Per-slot inputs
  input  wire logic [hpa_pkg::NSLOT-1:0]  slot_interlock_switch_closed,
  input  wire logic [hpa_pkg::NSLOT-1:0]  slot_interlock_switch_override,
  input  wire logic [hpa_pkg::NSLOT-1:0]  slot_aux_oc,
  input  wire logic [hpa_pkg::NSLOT-1:0]  slot_aux_good,
  input  wire logic [hpa_pkg::NSLOT-1:0]  main_power_fault,
  input  wire logic [hpa_pkg::NSLOT-1:0]  slot_wake_event_in_n,
  input  wire logic [hpa_pkg::NSLOT-1:0]  bus_cap_above_gnd,
  input  wire logic [hpa_pkg::NSLOT-1:0]  bus_cap_open,
  // Per-slot outputs
  output logic [hpa_pkg::NSLOT-1:0]       slot_aux_supply,
  output logic [hpa_pkg::NSLOT-1:0]       slot_main_enable,
  output logic [hpa_pkg::NSLOT-1:0]       attention_indicator,
  output logic [hpa_pkg::NSLOT-1:0]       power_indicator,
  // Shared open-drain wake line
  output logic                            gated_wake_event_out_o,
  output logic                            gated_wake_event_out_oe
);
  import hpa_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_d;
  logic [SYNC_W-1:0] sync_q;
  logic              link_clk_s;
  logic              stat_in_s;
  logic              stat_pin_s;
  logic              ctl_in_s;
  logic              ctl_pin_s;
  logic              mpv_s;
  logic              test_s;
  logic              uv_s;
  logic [NSLOT-1:0]  sw_cl_s;
  logic [NSLOT-1:0]  sw_ov_s;
  logic [NSLOT-1:0]  oc_s;
  logic [NSLOT-1:0]  good_s;
  logic [NSLOT-1:0]  pflt_s;
  logic [NSLOT-1:0]  wake_n_s;
  logic [NSLOT-1:0]  cap_gnd_s;
  logic [NSLOT-1:0]  cap_open_s;

  assign sync_d = {bus_cap_open, bus_cap_above_gnd, slot_wake_event_in_n,
                   main_power_fault, slot_aux_good, slot_aux_oc,
                   slot_interlock_switch_override, slot_interlock_switch_closed,
                   aux_in_uv, test_select, main_power_valid,
                   control_chain_out_i, control_chain_in,
                   status_chain_out_i, status_chain_in, link_clk};

  hpa_sync #(.W(SYNC_W)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (sync_d),
    .rst_val ('0),
    .q       (sync_q)
  );

  assign {cap_open_s, cap_gnd_s, wake_n_s, pflt_s, good_s, oc_s, sw_ov_s, sw_cl_s,
          uv_s, test_s, mpv_s, ctl_pin_s, ctl_in_s, stat_pin_s, stat_in_s,
          link_clk_s} = sync_q;

  // ----------------------------------------------------------------
  // Edge detection, strap capture and chain forwarding
  // ----------------------------------------------------------------
  logic        mpv_q;
  logic        link_q;
  logic        mpv_rise;
  logic        link_rise;
  logic [1:0]  strap_q;
  logic        test_rise_q;

  assign mpv_rise  = mpv_s & ~mpv_q;
  assign link_rise = link_clk_s & ~link_q;

  // Previous levels for edge finding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mpv_q  <= 1'b0;
      link_q <= 1'b0;
    end else begin
      mpv_q  <= mpv_s;
      link_q <= link_clk_s;
    end
  end

  // Straps caught while the pins are still undriven, before oe rises
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_q     <= STRAP_RST;
      test_rise_q <= 1'b0;
    end else if (mpv_rise) begin
      strap_q     <= {ctl_pin_s, stat_pin_s};
      test_rise_q <= test_s;
    end
  end

  // Chain pins released while main power is not valid, so straps read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_chain_out_oe  <= 1'b0;
      control_chain_out_oe <= 1'b0;
    end else begin
      status_chain_out_oe  <= mpv_s;
      control_chain_out_oe <= mpv_s;
    end
  end

  // One-bit pass stage per chain on each link clock rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_chain_out_o  <= CHAIN_IDLE;
      control_chain_out_o <= CHAIN_IDLE;
    end else if (link_rise) begin
      status_chain_out_o  <= stat_in_s;
      control_chain_out_o <= ctl_in_s;
    end
  end

  // ----------------------------------------------------------------
  // Slots
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q;
  logic [NSLOT-1:0]  aux_en;
  logic [NSLOT-1:0]  wake_conn;
  logic [NSLOT-1:0]  aux_flt;
  logic [NSLOT-1:0]  any_flt;
  logic [NSLOT-1:0]  mid_lvl;
  logic [NSLOT-1:0]  pwr_req;
  logic [NSLOT-1:0]  att_d;
  logic [NSLOT-1:0]  pind_d;
  logic [NSLOT-1:0]  men_d;
  logic [NSLOT-1:0]  wake_pull;
  logic [2*NSLOT-1:0] cap_bits;

  assign pwr_req = ctrl_q[CTRL_PWR_REQ +: NSLOT];

  genvar s;
  generate
    for (s = 0; s < NSLOT; s++) begin : g_slot
      // Override level counts as open for the aux supply
      hpa_slot #(.DELAY_CYC(WAKE_DELAY)) u_slot (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .sw_closed   (sw_cl_s[s] & ~sw_ov_s[s]),
        .aux_in_uv   (uv_s),
        .aux_oc      (oc_s[s]),
        .aux_good    (good_s[s]),
        .aux_en_q    (aux_en[s]),
        .wake_conn_q (wake_conn[s]),
        .aux_fault   (aux_flt[s])
      );

      assign any_flt[s] = aux_flt[s] | pflt_s[s];
      assign mid_lvl[s] = ~sw_cl_s[s] & ~sw_ov_s[s];

      // Attention source by priority: override, no power, test, mid level
      assign att_d[s] = sw_ov_s[s]  ? pflt_s[s] :
                        !mpv_s      ? aux_flt[s] :
                        test_s      ? any_flt[s] :
                        mid_lvl[s]  ? pflt_s[s] :
                        ctrl_q[CTRL_ATT + s];
      assign pind_d[s] = (mpv_s & test_s) ? pwr_req[s] :
                         ctrl_q[CTRL_PWR_IND + s];
      assign men_d[s]  = sw_ov_s[s] |
                         (mpv_s & pwr_req[s] & ~pflt_s[s]);
      assign wake_pull[s] = wake_conn[s] & ~wake_n_s[s];
      // Ground 00, pull-down 01, open 11
      assign cap_bits[2*s]   = cap_gnd_s[s];
      assign cap_bits[2*s+1] = cap_gnd_s[s] & cap_open_s[s];
    end
  endgenerate

  // Registered pin outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_aux_supply     <= '0;
      slot_main_enable    <= '0;
      attention_indicator <= '0;
      power_indicator     <= '0;
    end else begin
      slot_aux_supply     <= aux_en;
      slot_main_enable    <= men_d;
      attention_indicator <= att_d;
      power_indicator     <= pind_d;
    end
  end

  // Open drain: only ever pulls low, so several devices can share it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gated_wake_event_out_o  <= 1'b0;
      gated_wake_event_out_oe <= 1'b0;
    end else begin
      gated_wake_event_out_o  <= 1'b0;
      gated_wake_event_out_oe <= |wake_pull;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [NSLOT-1:0]  aux_flt_q;
  logic [NSLOT-1:0]  wake_conn_q;
  logic [IRQ_W-1:0]  irq_ev;
  logic [IRQ_W-1:0]  irq_stat_q;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [IRQ_W-1:0]  irq_clr;

  assign irq_ev = {mpv_rise, wake_conn & ~wake_conn_q, aux_flt & ~aux_flt_q};

  // Event history for rising-edge events
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_flt_q   <= '0;
      wake_conn_q <= '0;
    end else begin
      aux_flt_q   <= aux_flt;
      wake_conn_q <= wake_conn;
    end
  end

  // Sticky bits: a new event wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= IRQ_RST;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
      irq        <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave, one write and one read at a time
  // ----------------------------------------------------------------
  logic [3:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic              wlo_q;
  logic              aw_held;
  logic              w_held;
  logic              wr_go;
  logic              wr_ok;
  logic              rd_ok;
  logic [ST_W-1:0]   status;
  logic [31:0]       rd_word;

  assign aw_held = ~s_axi_awready;
  assign w_held  = ~s_axi_wready;
  assign wr_go   = aw_held & w_held & ~s_axi_bvalid;
  assign wr_ok   = (awaddr_q == ADDR_CTRL) | (awaddr_q == ADDR_IRQ_STAT) |
                   (awaddr_q == ADDR_IRQ_MASK);
  assign irq_clr = (wr_go && awaddr_q == ADDR_IRQ_STAT && wlo_q) ?
                   wdata_q[IRQ_W-1:0] : '0;

  // Fault fields read as zero while main power is not valid
  assign status = {cap_bits, test_rise_q, mpv_s, strap_q, aux_en, wake_conn,
                   mpv_s ? any_flt : {NSLOT{1'b0}},
                   mpv_s ? aux_flt : {NSLOT{1'b0}}};
  assign rd_ok  = (s_axi_araddr == ADDR_CTRL) | (s_axi_araddr == ADDR_STATUS) |
                  (s_axi_araddr == ADDR_IRQ_STAT) | (s_axi_araddr == ADDR_IRQ_MASK);
  assign rd_word = (s_axi_araddr == ADDR_CTRL)     ? 32'(ctrl_q) :
                   (s_axi_araddr == ADDR_STATUS)   ? 32'(status) :
                   (s_axi_araddr == ADDR_IRQ_STAT) ? 32'(irq_stat_q) :
                   (s_axi_araddr == ADDR_IRQ_MASK) ? 32'(irq_mask_q) : 32'h0000_0000;

  // Write channels taken independently, then one response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wlo_q         <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wlo_q        <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control and mask registers; only the low byte lane carries fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= CTRL_RST;
      irq_mask_q <= IRQ_RST;
    end else if (wr_go && wlo_q) begin
      if (awaddr_q == ADDR_CTRL) begin
        ctrl_q <= wdata_q[CTRL_W-1:0];
      end
      if (awaddr_q == ADDR_IRQ_MASK) begin
        irq_mask_q <= wdata_q[IRQ_W-1:0];
      end
    end
  end

  // Read: address taken, data one cycle later, held until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : hpa_aux_fault_logic

// File: hpa_checker_asserts.sv
// Property checker bound to the hot-plug aux fault logic top
`timescale 1ns/100ps
module hpa_checker (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Causes
  input wire logic       main_power_valid,
  input wire logic       aux_in_uv,
  input wire logic [1:0] slot_interlock_switch_closed,
  input wire logic [1:0] slot_interlock_switch_override,
  input wire logic [1:0] main_power_fault,
  // Outputs under watch
  input wire logic [1:0] slot_aux_supply,
  input wire logic [1:0] slot_main_enable,
  input wire logic [1:0] attention_indicator,
  input wire logic       gated_wake_event_out_o,
  input wire logic       gated_wake_event_out_oe,
  input wire logic       status_chain_out_oe,
  input wire logic       control_chain_out_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Short aliases keep each property on one line
  wire [1:0] swc = slot_interlock_switch_closed;
  wire [1:0] swo = slot_interlock_switch_override;
  // Six held cycles cover the two sync flops and the output register
  sequence s_uv_held; aux_in_uv [*6]; endsequence
  sequence s_dark_uv; (!main_power_valid && aux_in_uv && swo == 2'h0) [*6]; endsequence
  a_aux_needs_sw: assert property (!swc[0] [*6] |=> !slot_aux_supply[0])
    else $error("Slot 0 aux on with switch open");
  a_uv_cuts_aux: assert property (s_uv_held |=> slot_aux_supply == 2'h0)
    else $error("Aux on during input undervoltage");
  a_wake_od_low: assert property (gated_wake_event_out_o == 1'b0)
    else $error("Wake line driven high");
  a_wake_needs_aux: assert property (gated_wake_event_out_oe |-> slot_aux_supply != 2'h0)
    else $error("Wake connected without aux");
  a_ovr_main_en: assert property (swo[0] [*6] |=> slot_main_enable[0] && !slot_aux_supply[0])
    else $error("Override did not enable slot 0");
  a_dark_shows_aux: assert property (s_dark_uv |=> attention_indicator == 2'h3)
    else $error("Attention not showing aux fault");
  a_ovr_shows_flt: assert property ((swo[0] && main_power_fault[0]) [*6] |=> attention_indicator[0])
    else $error("Attention not showing main fault");
  a_chain_quiet: assert property (!main_power_valid [*6] |=> !status_chain_out_oe && !control_chain_out_oe)
    else $error("Chain pin driven without main power");
endmodule : hpa_checker
bind hpa_aux_fault_logic hpa_checker hpa_checker_i (.*);

// File: hpa_hp_ctl_model.sv
// Behavioural hot-plug controller and downstream device on the serial link
`timescale 1ns/100ps
module hpa_hp_ctl_model (
  // Frame request
  input  wire logic go,
  // Link toward the device
  output logic      link_clk,
  output logic      ctl_dat,
  output logic      sts_dat
);
  // Idle link: clock parked, data at pull-up level
  initial begin
    link_clk = 1'b0; ctl_dat = 1'b1; sts_dat = 1'b1;
  end
  // Eight-bit frame, data set half a period before each rise
  always @(posedge go) begin
    for (int i = 0; i < 8; i++) begin
      ctl_dat = i[0]; sts_dat = ~i[0];
      #160 link_clk = 1'b1;
      #160 link_clk = 1'b0;
    end
    ctl_dat = 1'b1; sts_dat = 1'b1;
  end
endmodule : hpa_hp_ctl_model

// File: tb_top.sv
// Self-checking bench for the hot-plug aux fault logic
`timescale 1ns/100ps
module tb_top;
  // Pins, joined to the design by name
  logic aclk, aresetn, mpv, uv, go, test_select, irq, link_clk, status_chain_in, control_chain_in;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, status_chain_out_o;
  logic status_chain_out_oe, control_chain_out_o, control_chain_out_oe, gated_wake_event_out_o;
  logic gated_wake_event_out_oe, status_chain_out_i, control_chain_out_i;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, sw, ov, mf, slot_aux_oc, slot_aux_good, bus_cap_open;
  logic [1:0] slot_wake_event_in_n, bus_cap_above_gnd, slot_aux_supply, slot_main_enable;
  logic [1:0] attention_indicator, power_indicator;
  int bad_count, n_checks;
  wire main_power_valid = mpv, aux_in_uv = uv;
  wire [1:0] slot_interlock_switch_closed = sw, slot_interlock_switch_override = ov;
  wire [1:0] main_power_fault = mf;
  // Released status pin rises to its pull-up; control pin is strapped low
  assign status_chain_out_i = status_chain_out_oe ? status_chain_out_o : 1'b1;
  assign control_chain_out_i = control_chain_out_oe ? control_chain_out_o : 1'b0;
  hpa_aux_fault_logic #(.WAKE_DELAY(4)) hpa_aux_fault_logic_i (.*);
  hpa_hp_ctl_model hpa_hp_ctl_model_i (.go(go), .link_clk(link_clk), .ctl_dat(control_chain_in),
    .sts_dat(status_chain_in));
  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task ck(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : ck
  task w(input int n);
    repeat (n) @(posedge aclk);
  endtask : w
  // One AXI4-Lite access; each channel is dropped at the edge that takes it
  task ax(input bit wr, input logic [3:0] a, input logic [31:0] d);
    if (wr) begin
      s_axi_awaddr <= a; s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      ck(s_axi_bresp, 2'h0);
      s_axi_bready <= 1'b0;
    end else begin
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      ck(s_axi_rresp, 2'h0);
      rd = s_axi_rdata; s_axi_rready <= 1'b0;
    end
    w(1);
  endtask : ax
  task t_strap;
    w(4); mpv <= 1'b1; w(8); ax(0, 4'h4, 0);
    ck(rd[10:8], 3'h5);
    ck(rd[15:12], 4'h0);
    bus_cap_above_gnd <= 2'h3; bus_cap_open <= 2'h2; w(8); ax(0, 4'h4, 0);
    ck(rd[15:12], 4'hD);
    go <= 1'b1; w(80); go <= 1'b0;
    ck({status_chain_out_o, control_chain_out_o}, 2'h1);
  endtask : t_strap
  task t_slot;
    sw <= 2'h1; slot_aux_good <= 2'h1; slot_wake_event_in_n <= 2'h2; w(6);
    ck({gated_wake_event_out_oe, slot_aux_supply}, 3'h1);
    w(10); ax(0, 4'h4, 0);
    ck(rd[5:4], 2'h1);
    ck({gated_wake_event_out_oe, gated_wake_event_out_o}, 2'h2);
    sw <= 2'h0; w(6);
    ck({gated_wake_event_out_oe, slot_aux_supply}, 3'h0);
    slot_wake_event_in_n <= 2'h3;
  endtask : t_slot
  task t_fault;
    ax(1, 4'hC, 32'h1F); sw <= 2'h2; slot_aux_good <= 2'h2; w(8);
    slot_aux_oc <= 2'h2; w(4); slot_aux_oc <= 2'h0; w(6);
    ck(slot_aux_supply, 2'h0);
    ax(0, 4'h4, 0);
    ck(rd[3:0], 4'hA);
    ck(irq, 1'b1);
    ax(1, 4'h8, 32'h1F); w(3);
    ck(irq, 1'b0);
    sw <= 2'h0; w(8); ax(0, 4'h4, 0);
    ck(rd[1:0], 2'h0);
  endtask : t_fault
  task t_att;
    ax(1, 4'h0, 32'h1); mf <= 2'h1; w(8);
    ck(attention_indicator, 2'h1);
    ov <= 2'h1; w(8);
    ck({slot_main_enable[0], attention_indicator}, 3'h5);
    ov <= 2'h0; sw <= 2'h3; test_select <= 1'b1; w(8);
    ck({power_indicator, attention_indicator}, 4'h5);
    mpv <= 1'b0; uv <= 1'b1; w(8);
    ck(attention_indicator, 2'h3);
  endtask : t_att
  task results;
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  // Main sequence, reset held for 20 cycles
  initial begin
    {aresetn, mpv, uv, go, test_select, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {sw, ov, mf, slot_aux_oc, slot_aux_good, bus_cap_above_gnd, bus_cap_open} = '0;
    s_axi_wstrb = 4'hF; slot_wake_event_in_n = 2'h3;
    w(20); aresetn <= 1'b1;
    t_strap; t_slot; t_fault; t_att;
    results;
  end
  // Watchdog: the run needs well under 2000 cycles
  initial begin
    #200000;
    bad_count++;
    results;
  end
endmodule : tb_top
